//--- src/psd_pkg.sv
// shared constants and types of the sop delay register bank
package psd_pkg;
   // register addresses on the management interface
   localparam logic [15:0] ADDR_RX_DEL = 16'h9429;
   localparam logic [15:0] ADDR_TX_DEL = 16'h942A;
   localparam logic [15:0] ADDR_DEPTH = 16'h9602;
   localparam logic [15:0] ADDR_WAKE = 16'hA000;
   localparam logic [15:0] ADDR_LV10 = 16'hB403;
   // reset values
   localparam logic [15:0] RST_RX_DEL = 16'h0000;
   localparam logic [12:0] RST_TX_DEL = 13'h0000;
   localparam logic RST_DEPTH = 1'b1;
   localparam logic RST_LV10 = 1'b1;
   localparam logic [15:0] RST_WAKE = 16'h0000;
   localparam logic [15:0] WAKE_MAX = 16'hFFFF;
   localparam logic [15:0] WAKE_ONE = 16'h0001;
   // field layout
   localparam int RX10_LSB = 11;
   localparam int RX100_LSB = 6;
   localparam int RX_FLD_W = 5;
   localparam int TX10_LSB = 8;
   localparam int TX10_W = 5;
   localparam int TX100_LSB = 4;
   localparam int TX100_W = 4;
   localparam int TX_KEEP_W = 13;
   localparam int ONE_BIT = 0;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TX_UNIT_NS = 8;
   localparam int DLY_ACC_W = 9;
   // management frame layout
   localparam logic [5:0] PRE_LEN = 6'h20;
   localparam logic [5:0] HDR_LAST = 6'h0C;
   localparam logic [5:0] DATA_LAST = 6'h0F;
   localparam logic [1:0] OP_ADDR = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_RDINC = 2'h2;
   // one management access handed from the serial port to the bank
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } psd_mreq_t;
endpackage

//--- src/psd_delay.sv
// one start-of-packet delay line with cancel
`timescale 1ns/100ps
module psd_delay #(
   parameter int ACC_W = 9,
   parameter int STEP = 1
) (
   input wire logic ref_clk, // system clock
   input wire logic sys_rst, // sync reset, high
   input wire logic start, // raw marker event
   input wire logic cancel, // drop pending marker
   input wire logic advance, // add one step
   input wire logic [ACC_W-1:0] target, // delay in accumulator units; each advance adds STEP
   output logic fire // delayed marker pulse
);
   logic busy_r, busy_nxt, fire_r, fire_nxt;
   logic [ACC_W-1:0] acc_r, acc_nxt, tgt_r, tgt_nxt;

   // a new start restarts timing; only one marker in flight
   always_comb begin
      busy_nxt = busy_r;
      acc_nxt = acc_r;
      tgt_nxt = tgt_r;
      fire_nxt = 1'b0;
      if (busy_r) begin
         if (acc_r >= tgt_r) begin
            fire_nxt = 1'b1;
            busy_nxt = 1'b0;
         end else if (advance) begin
            acc_nxt = acc_r + ACC_W'(STEP);
         end
      end
      if (start) begin
         busy_nxt = 1'b1;
         acc_nxt = '0;
         tgt_nxt = target;
      end
      // cancel wins so a disabled path never emits
      if (cancel) begin
         busy_nxt = 1'b0;
         fire_nxt = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy_r <= 1'b0;
         acc_r <= '0;
         tgt_r <= '0;
         fire_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         acc_r <= acc_nxt;
         tgt_r <= tgt_nxt;
         fire_r <= fire_nxt;
      end
   end

   assign fire = fire_r;
endmodule

//--- src/psd_mdio.sv
// serial management port, indirect addressed frames
`timescale 1ns/100ps
module psd_mdio #(
   parameter logic [4:0] PHY_ADDR = 5'h00
) (
   input wire logic ref_clk, // system clock
   input wire logic sys_rst, // sync reset, high
   input wire logic mdcPin, // management clock pin
   input wire logic mdioIn, // data pin, input side
   output logic mdioOut, // data pin, output side
   output logic mdioOe, // data pin enable, high drives
   output psd_pkg::psd_mreq_t req, // access to the bank
   input wire logic [15:0] rdData // read value for req.addr
);
   typedef enum {S_PRE, S_HDR, S_TURN, S_DATA} psd_mst_t;
   psd_mst_t st_r, st_nxt;
   logic mdcS1, mdcS2, mdcS3, datS1, datS2;
   logic [5:0] cnt_r, cnt_nxt;
   logic [15:0] sh_r, sh_nxt, ptr_r, ptr_nxt, out_r, out_nxt;
   logic [1:0] op_r, op_nxt;
   logic hit_r, hit_nxt, oe_r, oe_nxt, do_r, do_nxt;
   psd_pkg::psd_mreq_t req_r, req_nxt;
   logic rise, bitIn, isRd;
   logic [12:0] hdr;
   logic [15:0] word;

   // pins are asynchronous: two flops, third only for the edge
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         // idle level of the clock pin is high: no false rise after reset
         mdcS1 <= 1'b1;
         mdcS2 <= 1'b1;
         mdcS3 <= 1'b1;
         datS1 <= 1'b1;
         datS2 <= 1'b1;
      end else begin
         mdcS1 <= mdcPin;
         mdcS2 <= mdcS1;
         mdcS3 <= mdcS2;
         datS1 <= mdioIn;
         datS2 <= datS1;
      end
   end

   assign rise = mdcS2 && !mdcS3;
   assign bitIn = datS2;
   assign hdr = {sh_r[11:0], bitIn};
   assign word = {sh_r[14:0], bitIn};
   assign isRd = op_r[1];

   // frame walker, one step per management clock rise
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      ptr_nxt = ptr_r;
      out_nxt = out_r;
      op_nxt = op_r;
      hit_nxt = hit_r;
      oe_nxt = oe_r;
      do_nxt = do_r;
      req_nxt = req_r;
      req_nxt.wr = 1'b0;
      req_nxt.rd = 1'b0;
      req_nxt.addr = ptr_r;
      // read data is taken the cycle after the read strobe
      if (req_r.rd) begin
         out_nxt = rdData;
      end
      if (rise) begin
         case (st_r)
            S_PRE: begin
               if (bitIn) begin
                  cnt_nxt = (cnt_r == psd_pkg::PRE_LEN) ? cnt_r : cnt_r + 6'h01;
               end else if (cnt_r == psd_pkg::PRE_LEN) begin
                  st_nxt = S_HDR;
                  cnt_nxt = '0;
               end else begin
                  cnt_nxt = '0;
               end
            end
            S_HDR: begin
               sh_nxt = {sh_r[14:0], bitIn};
               cnt_nxt = cnt_r + 6'h01;
               // thirteenth header bit: second start bit through last device bit
               if (cnt_r == psd_pkg::HDR_LAST) begin
                  op_nxt = hdr[11:10];
                  hit_nxt = !hdr[12] && (hdr[9:5] == PHY_ADDR);
                  st_nxt = S_TURN;
                  cnt_nxt = '0;
                  req_nxt.rd = !hdr[12] && (hdr[9:5] == PHY_ADDR) && hdr[11];
               end
            end
            S_TURN: begin
               cnt_nxt = cnt_r + 6'h01;
               if (cnt_r == '0) begin
                  oe_nxt = hit_r && isRd;
                  do_nxt = 1'b0;
               end else begin
                  st_nxt = S_DATA;
                  cnt_nxt = '0;
                  do_nxt = out_r[15];
                  out_nxt = {out_r[14:0], 1'b0};
               end
            end
            S_DATA: begin
               sh_nxt = word;
               cnt_nxt = cnt_r + 6'h01;
               do_nxt = out_r[15];
               out_nxt = {out_r[14:0], 1'b0};
               if (cnt_r == psd_pkg::DATA_LAST) begin
                  st_nxt = S_PRE;
                  cnt_nxt = '0;
                  oe_nxt = 1'b0;
                  if (hit_r && op_r == psd_pkg::OP_ADDR) begin
                     ptr_nxt = word;
                  end
                  if (hit_r && op_r == psd_pkg::OP_WRITE) begin
                     req_nxt.wr = 1'b1;
                     req_nxt.wdata = word;
                  end
                  if (hit_r && op_r == psd_pkg::OP_RDINC) begin
                     ptr_nxt = ptr_r + 16'h0001;
                  end
               end
            end
            default: st_nxt = S_PRE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_r <= S_PRE;
         cnt_r <= '0;
         sh_r <= '0;
         ptr_r <= '0;
         out_r <= '0;
         op_r <= '0;
         hit_r <= 1'b0;
         oe_r <= 1'b0;
         do_r <= 1'b0;
         req_r <= '0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         ptr_r <= ptr_nxt;
         out_r <= out_nxt;
         op_r <= op_nxt;
         hit_r <= hit_nxt;
         oe_r <= oe_nxt;
         do_r <= do_nxt;
         req_r <= req_nxt;
      end
   end

   assign mdioOut = do_r;
   assign mdioOe = oe_r;
   assign req = req_r;
endmodule

//--- src/psd_sop_regs.sv
// sop delay, fifo depth unit, wake fault count and 10m low-voltage registers
// What this block does
// (R1) rx marker delay at 10M, rx clocks
// (R2) rx marker delay at 100M, rx clocks
// (R3) tx marker delay at 10M, 8 ns units
// (R4) tx marker delay at 100M, 8 ns units
// (R5) software should set 10M tx delay twenty
// (R6) software should set 100M tx delay zero
// (R7) depth unit bit: bytes or nibbles, resets one
// (R8) byte counting uses larger prefill, longer latency
// (R9) sixteen-bit counter of wake faults
// (R10) reading wake fault counter clears it
// (R11) low-voltage 10M variant while bit set
// (R12) markers only while their enable set
// (R13) tx marker taken after the transmit fifo
// (R14) wake fault counter saturates until read
`timescale 1ns/100ps
module psd_sop_regs #(
   parameter logic [4:0] PHY_ADDR = 5'h00,
   parameter logic [3:0] PREFILL_NIB = 4'h2,
   parameter logic [3:0] PREFILL_BYTE = 4'h4
) (
   input wire logic ref_clk, // 100 MHz system clock
   input wire logic sys_rst, // sync reset, high
   input wire logic mdcPin, // management clock pin
   input wire logic mdioIn, // management data, input side
   output logic mdioOut, // management data, output side
   output logic mdioOe, // management data drive enable
   input wire logic speed100, // link is 100M when high
   input wire logic rxClkTick, // one pulse per rx clock cycle
   input wire logic rxSopRaw, // undelayed rx marker pulse
   input wire logic txSopRaw, // undelayed tx marker, fifo output
   input wire logic rxMarkerEnable, // rx marker generation on
   input wire logic txMarkerEnable, // tx marker generation on
   input wire logic wakeFault, // wake sequence overran, pulse
   output logic rxSop, // delayed rx marker pulse
   output logic txSop, // delayed tx marker pulse
   output logic lowVolt10m, // 10M runs low-voltage variant
   output logic fifoDepthInBytes, // fifo depth counted in bytes
   output logic [3:0] fifoPrefill // tx fifo prefill, nibbles
);
   logic [15:0] rxDel_r, rxDel_nxt;
   logic [12:0] txDel_r, txDel_nxt;
   logic depth_r, depth_nxt, lv10_r, lv10_nxt;
   logic [15:0] wake_r, wake_nxt, rdData;
   logic [3:0] prefill_r, prefill_nxt;
   logic cntRead, rxStart, txStart;
   logic [psd_pkg::RX_FLD_W-1:0] rxFld10, rxFld100;
   logic [psd_pkg::TX10_W-1:0] txFld10;
   logic [psd_pkg::TX100_W-1:0] txFld100;
   logic [psd_pkg::DLY_ACC_W-1:0] rxTarget, txTarget;
   psd_pkg::psd_mreq_t req;

   // serial management port
   psd_mdio #(
      .PHY_ADDR(PHY_ADDR)
   ) u_mdio (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .mdcPin(mdcPin),
      .mdioIn(mdioIn),
      .mdioOut(mdioOut),
      .mdioOe(mdioOe),
      .req(req),
      .rdData(rdData)
   );

   // field views of the delay registers
   assign rxFld10 = rxDel_r[psd_pkg::RX10_LSB +: psd_pkg::RX_FLD_W];
   assign rxFld100 = rxDel_r[psd_pkg::RX100_LSB +: psd_pkg::RX_FLD_W];
   assign txFld10 = txDel_r[psd_pkg::TX10_LSB +: psd_pkg::TX10_W];
   assign txFld100 = txDel_r[psd_pkg::TX100_LSB +: psd_pkg::TX100_W];

   // rx delay counts rx clock ticks, picked by speed at start
   assign rxTarget = speed100 ? psd_pkg::DLY_ACC_W'(rxFld100) // see (R2)
                              : psd_pkg::DLY_ACC_W'(rxFld10); // see (R1)
   // tx delay in ns; the 10 ns clock steps past each 8 ns unit
   assign txTarget = speed100
      ? psd_pkg::DLY_ACC_W'(txFld100 * psd_pkg::TX_UNIT_NS) // see (R4)
      : psd_pkg::DLY_ACC_W'(txFld10 * psd_pkg::TX_UNIT_NS); // see (R3)

   // raw markers pass only while their enable is set
   assign rxStart = rxSopRaw && rxMarkerEnable; // see (R12)
   // tx raw marker is tapped at the fifo output, not its input
   assign txStart = txSopRaw && txMarkerEnable; // see (R12) see (R13)

   psd_delay #(
      .ACC_W(psd_pkg::DLY_ACC_W),
      .STEP(1)
   ) u_rxDelay (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(rxStart),
      .cancel(!rxMarkerEnable), // see (R12)
      .advance(rxClkTick), // see (R1) see (R2)
      .target(rxTarget),
      .fire(rxSop)
   );

   psd_delay #(
      .ACC_W(psd_pkg::DLY_ACC_W),
      .STEP(psd_pkg::CLK_PERIOD_NS)
   ) u_txDelay (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(txStart),
      .cancel(!txMarkerEnable), // see (R12)
      .advance(1'b1), // see (R3) see (R4)
      .target(txTarget),
      .fire(txSop)
   );

   // a read of the counter is its clear; strobe comes with the address
   assign cntRead = req.rd && (req.addr == psd_pkg::ADDR_WAKE); // see (R10)

   // read mux; unmapped addresses and reserved bits read zero
   always_comb begin
      rdData = '0;
      case (req.addr)
         psd_pkg::ADDR_RX_DEL: rdData = rxDel_r;
         psd_pkg::ADDR_TX_DEL: rdData = {3'h0, txDel_r};
         psd_pkg::ADDR_DEPTH: rdData = {15'h0000, depth_r};
         psd_pkg::ADDR_WAKE: rdData = wake_r;
         psd_pkg::ADDR_LV10: rdData = {15'h0000, lv10_r};
         default: rdData = '0;
      endcase
   end

   // register writes, counter update and prefill choice
   always_comb begin
      rxDel_nxt = rxDel_r;
      txDel_nxt = txDel_r;
      depth_nxt = depth_r;
      lv10_nxt = lv10_r;
      wake_nxt = wake_r;
      // nibble interface: byte counting needs the deeper prefill
      prefill_nxt = depth_r ? PREFILL_BYTE : PREFILL_NIB; // see (R7) see (R8)
      if (req.wr) begin
         case (req.addr)
            psd_pkg::ADDR_RX_DEL: rxDel_nxt = req.wdata;
            psd_pkg::ADDR_TX_DEL: txDel_nxt = req.wdata[psd_pkg::TX_KEEP_W-1:0];
            psd_pkg::ADDR_DEPTH: depth_nxt = req.wdata[psd_pkg::ONE_BIT]; // see (R7)
            psd_pkg::ADDR_LV10: lv10_nxt = req.wdata[psd_pkg::ONE_BIT]; // see (R11)
            default: ;
         endcase
      end
      // a fault in the read cycle is kept: it becomes the new count
      if (wakeFault) begin
         if (cntRead) begin
            wake_nxt = psd_pkg::WAKE_ONE; // see (R10)
         end else if (wake_r != psd_pkg::WAKE_MAX) begin
            wake_nxt = wake_r + psd_pkg::WAKE_ONE; // see (R9)
         end else begin
            wake_nxt = wake_r; // see (R14)
         end
      end else if (cntRead) begin
         wake_nxt = psd_pkg::RST_WAKE; // see (R10)
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rxDel_r <= psd_pkg::RST_RX_DEL;
         txDel_r <= psd_pkg::RST_TX_DEL;
         depth_r <= psd_pkg::RST_DEPTH;
         lv10_r <= psd_pkg::RST_LV10;
         wake_r <= psd_pkg::RST_WAKE;
         prefill_r <= PREFILL_BYTE;
      end else begin
         rxDel_r <= rxDel_nxt;
         txDel_r <= txDel_nxt;
         depth_r <= depth_nxt;
         lv10_r <= lv10_nxt;
         wake_r <= wake_nxt;
         prefill_r <= prefill_nxt;
      end
   end

   // low-voltage choice only matters on 10M links; the phy reads it there
   assign lowVolt10m = lv10_r;
   assign fifoDepthInBytes = depth_r;
   assign fifoPrefill = prefill_r;

   // checks on the bank and the marker paths
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   chk_rx10_zero: assert property ( // see (R1)
      rxStart && !speed100 && rxFld10 == 5'h00 ##1 rxMarkerEnable |=> rxSop)
      else $error("rx marker at 10M with zero delay not on time");

   chk_rx100_zero: assert property ( // see (R2)
      rxStart && speed100 && rxFld100 == 5'h00 ##1 rxMarkerEnable |=> rxSop)
      else $error("rx marker at 100M with zero delay not on time");

   // seventeen quiet cycles written as two runs of eight and one more
   chk_tx10_twenty: assert property ( // see (R3)
      txStart && !speed100 && txFld10 == 5'h14
      ##1 (txMarkerEnable && !txStart) [*8] ##1 (txMarkerEnable && !txStart) [*8]
      ##1 (txMarkerEnable && !txStart) |=> txSop)
      else $error("tx marker at 10M with 160 ns delay not on time");

   chk_tx10_early: assert property ( // see (R3)
      txStart && !speed100 && txFld10 == 5'h14 |=> !txSop [*8])
      else $error("tx marker at 10M fired too early");

   chk_tx100_zero: assert property ( // see (R4)
      txStart && speed100 && txFld100 == 4'h0
      ##1 (txMarkerEnable && !txStart) |=> txSop)
      else $error("tx marker at 100M with zero delay not on time");

   chk_rx_gate: assert property ( // see (R12)
      !rxMarkerEnable |=> !rxSop)
      else $error("rx marker emitted while disabled");

   chk_tx_gate: assert property ( // see (R12)
      !txMarkerEnable |=> !txSop)
      else $error("tx marker emitted while disabled");

   chk_prefill_bytes: assert property ( // see (R8)
      $rose(fifoDepthInBytes) |=> fifoPrefill == PREFILL_BYTE)
      else $error("prefill not raised for byte counting");

   chk_depth_write: assert property ( // see (R7)
      req.wr && req.addr == psd_pkg::ADDR_DEPTH
      |=> fifoDepthInBytes == $past(req.wdata[0]))
      else $error("depth unit bit not written");

   chk_lv10_write: assert property ( // see (R11)
      req.wr && req.addr == psd_pkg::ADDR_LV10
      |=> lowVolt10m == $past(req.wdata[0]))
      else $error("low-voltage enable not written");

   chk_wake_count: assert property ( // see (R9)
      wakeFault && !cntRead && wake_r != 16'hFFFF
      |=> wake_r == $past(wake_r) + 16'h0001)
      else $error("wake fault not counted");

   chk_read_clear: assert property ( // see (R10)
      cntRead |=> wake_r == (($past(wakeFault)) ? 16'h0001 : 16'h0000))
      else $error("wake counter not cleared by read");

   chk_wake_sat: assert property ( // see (R14)
      wake_r == 16'hFFFF && !cntRead |=> wake_r == 16'hFFFF)
      else $error("wake counter wrapped or dropped");

   cov_rx_marker: cover property (rxStart ##[1:40] rxSop);
   cov_tx_marker: cover property (txStart && !speed100 ##[1:30] txSop);
   cov_wake_sat: cover property (wake_r == 16'hFFFF && wakeFault);
   cov_read_clear: cover property (cntRead && wake_r != 16'h0000);
endmodule

//--- dv/psd_host_model.sv
// host model driving management frames onto the serial pins
`timescale 1ns/100ps
module psd_host_model #(
   parameter int HALF = 4
) (
   input wire logic ref_clk, // system clock
   input wire logic mdioOut, // block data output
   input wire logic mdioOe, // block drive enable
   output logic mdcPin, // management clock
   output logic mdioIn // resolved data wire
);
   logic hostBit = 1'b1;
   logic hostOe = 1'b0;
   initial mdcPin = 1'b1;
   // pull-up holds the wire high when nobody drives it
   assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);
   // one whole frame; on reads the host lets go from turnaround on
   task automatic xfer(input logic [1:0] op, input logic [15:0] data, output logic [15:0] rdv);
      logic [63:0] bits;
      bits = {32'hFFFFFFFF, 2'b00, op, 5'h00, 5'h00, 2'b10, data};
      rdv = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         @(posedge ref_clk);
         mdcPin <= 1'b0;
         hostBit <= bits[i];
         hostOe <= !(op[1] && i < 18);
         repeat (HALF) @(posedge ref_clk);
         mdcPin <= 1'b1;
         // value taken at the rising edge, before the block moves on
         if (i < 16)
            rdv = {rdv[14:0], mdioIn};
         repeat (HALF - 1) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      hostOe <= 1'b0;
   endtask
endmodule

//--- dv/test_psd_sop_regs.sv
// self-checking bench of the sop delay register bank
`timescale 1ns/100ps
module test_psd_sop_regs;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic mdcPin, mdioIn, mdioOut, mdioOe;
   logic speed100 = 1'b0, rxClkTick = 1'b0, rxSopRaw = 1'b0, txSopRaw = 1'b0;
   logic rxMarkerEnable = 1'b1, txMarkerEnable = 1'b1, wakeFault = 1'b0;
   logic rxSop, txSop, lowVolt10m, fifoDepthInBytes;
   logic [3:0] fifoPrefill;
   logic [31:0] seed = 32'h2E16;
   logic [15:0] rv, v;
   logic [1:0] tickCnt = 2'h0;
   logic [15:0] adr [6] = '{16'h9429, 16'h942A, 16'h9602, 16'hA000, 16'hB403, 16'h1234};
   logic [15:0] rst [6] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000};
   logic [15:0] msk [6] = '{16'hFFFF, 16'h1FFF, 16'h0001, 16'h0000, 16'h0001, 16'h0000};
   int num_errors = 0;
   int n_tests = 0;
   int c, n;

   initial forever #5 ref_clk = ~ref_clk;
   // rx clock tick every fourth cycle, free running
   always @(posedge ref_clk) begin
      tickCnt <= tickCnt + 2'h1;
      rxClkTick <= (tickCnt == 2'h3);
   end

   psd_sop_regs i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .mdcPin(mdcPin),
      .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe), .speed100(speed100),
      .rxClkTick(rxClkTick), .rxSopRaw(rxSopRaw), .txSopRaw(txSopRaw),
      .rxMarkerEnable(rxMarkerEnable), .txMarkerEnable(txMarkerEnable),
      .wakeFault(wakeFault), .rxSop(rxSop), .txSop(txSop), .lowVolt10m(lowVolt10m),
      .fifoDepthInBytes(fifoDepthInBytes), .fifoPrefill(fifoPrefill));
   psd_host_model i_host (.ref_clk(ref_clk), .mdioOut(mdioOut), .mdioOe(mdioOe),
      .mdcPin(mdcPin), .mdioIn(mdioIn));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // 8 ns units rounded up to whole 10 ns cycles, plus pipeline
   function automatic int tx_cycles(input int k);
      return (8 * k + 9) / 10 + 1;
   endfunction
   task automatic rnd(output logic [15:0] r);
      seed = xs(seed);
      r = seed[15:0];
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      logic [15:0] x;
      i_host.xfer(psd_pkg::OP_ADDR, a, x);
      i_host.xfer(psd_pkg::OP_WRITE, d, x);
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      logic [15:0] x;
      i_host.xfer(psd_pkg::OP_ADDR, a, x);
      i_host.xfer(2'h3, 16'h0000, d);
   endtask
   // raw marker pulse, then the cycle of the delayed one; -1 if none
   task automatic fire(input bit tx, output int cyc);
      cyc = -1;
      @(posedge ref_clk);
      if (tx)
         txSopRaw <= 1'b1;
      else
         rxSopRaw <= 1'b1;
      @(posedge ref_clk);
      txSopRaw <= 1'b0;
      rxSopRaw <= 1'b0;
      for (int k = 0; k < 200 && cyc < 0; k++) begin
         #1;
         if ((tx ? txSop : rxSop) === 1'b1)
            cyc = k;
         @(posedge ref_clk);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      chk({11'h0, lowVolt10m, fifoPrefill}, 16'h0014, "reset pins");
      // reset values, including the unmapped hole
      foreach (adr[i]) begin
         rd(adr[i], rv);
         chk(rv, rst[i], "reset value");
      end
      // random write and read back; reserved and read-only bits masked
      foreach (adr[i]) begin
         rnd(v);
         v = v | 16'hA001;
         wr(adr[i], v);
         rd(adr[i], rv);
         chk(rv, v & msk[i], "read back");
      end
      chk({10'h0, lowVolt10m, fifoDepthInBytes, fifoPrefill}, 16'h0034,
         "set pins");
      wr(16'h9602, 16'h0000);
      wr(16'hB403, 16'h0000);
      repeat (4) @(posedge ref_clk);
      chk({10'h0, lowVolt10m, fifoDepthInBytes, fifoPrefill}, 16'h0002,
         "clear pins");
      // rx delay per speed; the other field is random to catch a mix-up
      for (int t = 0; t < 4; t++) begin
         rnd(rv);
         n = (t == 0) ? 0 : (t == 1) ? 31 : int'(rv[4:0]);
         speed100 <= t[0];
         wr(16'h9429, t[0] ? {rv[15:11], n[4:0], 6'h00} : {n[4:0], rv[10:6], 6'h00});
         fire(1'b0, c);
         chk({15'h0, (n == 0) ? c == 1 : (c >= 4 * n - 2 && c <= 4 * n + 3)}, 16'h0001,
            "rx delay");
      end
      // tx delay: recommended settings first, then random
      for (int t = 0; t < 4; t++) begin
         rnd(rv);
         n = (t == 0) ? 20 : (t == 1) ? 0 : (t == 2) ? int'(rv[4:0]) : int'(rv[3:0]);
         speed100 <= t[0];
         wr(16'h942A, t[0] ? {3'h0, rv[12:8], n[3:0], 4'h0} : {3'h0, n[4:0], rv[7:4], 4'h0});
         fire(1'b1, c);
         chk(16'(c), 16'(tx_cycles(n)), "tx delay");
      end
      // enable dropped while a long rx marker is pending
      speed100 <= 1'b0;
      wr(16'h9429, 16'hF800);
      @(posedge ref_clk);
      rxSopRaw <= 1'b1;
      @(posedge ref_clk);
      rxSopRaw <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rxMarkerEnable <= 1'b0;
      @(posedge ref_clk);
      rxMarkerEnable <= 1'b1;
      n = 0;
      repeat (200) begin
         @(posedge ref_clk);
         #1;
         if (rxSop === 1'b1)
            n++;
      end
      chk(16'(n), 16'h0000, "rx cancel");
      txMarkerEnable <= 1'b0;
      fire(1'b1, c);
      chk(16'(c), 16'hFFFF, "tx disabled");
      txMarkerEnable <= 1'b1;
      // wake faults counted, then cleared by the read
      rnd(rv);
      n = int'(rv[4:0]) + 1;
      repeat (n) begin
         @(posedge ref_clk);
         wakeFault <= 1'b1;
         @(posedge ref_clk);
         wakeFault <= 1'b0;
      end
      rd(16'hA000, rv);
      chk(rv, 16'(n), "wake count");
      rd(16'hA000, rv);
      chk(rv, 16'h0000, "wake cleared");
      // burst past the top must stick at the maximum
      @(posedge ref_clk);
      wakeFault <= 1'b1;
      repeat (65540) @(posedge ref_clk);
      wakeFault <= 1'b0;
      rd(16'hA000, rv);
      chk(rv, 16'hFFFF, "wake saturate");
      rd(16'hA000, rv);
      chk(rv, 16'h0000, "wake clear max");
      summarize();
   end
endmodule
